// ### core/sxr_regs.vh
// Overview of operation
// (R1) Pulse release low one cycle to grant
// (R2) Float address/data and command after granting
// (R3) Agent drives buses two cycles after release
// (R4) Agent drops request two cycles after release
// (R5) Agent floats buses when request finished
// (R6) New processor request one cycle after float
// (R7) Check and parity follow primary bus timing
// (R8) External read and response are atomic
// (R9) Buses float one cycle before agent drives
// (R10) Agent read: command, address, one valid cycle
// (R11) Answer external read: final, error, one valid
// (R12) Master state, keep driving after read answer
// (R13) Null: command, one valid cycle, no data
// (R14) Null only returns interface to master
// (R15) Agent write: address cycle then data cycle
// (R16) Write data cycle final, single word only
// (R17) Agent answers reads after autonomous slave shift
// (R18) Non-coherent block fill marked exclusive dirty
// (R19) Any flagged error cycle means bus error
// (R20) Agent answers only pending processor reads
// (R21) Accept data on valid with identifier until final
// (R22) Config bit 0 picks Wxx or W pattern
// (R23) Independent transfer: no valid, then null
// (R24) Command MSB 0 address, 1 data cycle
// (R25) Type field: 0 read, 2 write, 3 null
// (R26) Agent sets reserved fields to one
`ifndef SXR_REGS_VH
`define SXR_REGS_VH

// Register map, byte addresses
`define SXR_ADDR_W 36
`define SXR_CFG_ADDR 36'hfff100000
`define SXR_STAT_ADDR 36'hfff100004
`define SXR_CFG_RST 3'h0
`define SXR_CFG_PAT_BIT 0
`define SXR_CFG_SWM_HI 2
`define SXR_CFG_SWM_LO 1
`define SXR_SWM_COMPAT 2'h0
`define SXR_ST_MASTER_BIT 0
`define SXR_ST_PERR_BIT 1
`define SXR_ST_BERR_BIT 2

// Command and data identifier fields
`define SXR_CMD_DATA_BIT 8
`define SXR_CMD_TYPE_HI 7
`define SXR_CMD_TYPE_LO 5
`define SXR_CMD_PROP_HI 4
`define SXR_CMD_PROP_LO 3
`define SXR_TYPE_READ 3'h0
`define SXR_TYPE_WRITE 3'h2
`define SXR_TYPE_NULL 3'h3
`define SXR_PROP_BLOCK 2'h2
`define SXR_DID_LAST_BIT 7
`define SXR_DID_ERR_BIT 5
`define SXR_DID_RESP_ERR 9'h1ff
`define SXR_DID_WR_MORE 9'h11f
`define SXR_DID_WR_LAST 9'h19f

// Counter reloads: last word index, or cycles minus one
`define SXR_BLOCK_LAST 3'h7
`define SXR_SINGLE_LAST 3'h0
`define SXR_HANDBACK_CYC 2'h3
`define SXR_WXX_IDLE 2'h1
`define SXR_COMPAT_DUMMY 2'h1

`endif

// ### core/sxr_sync.v
`timescale 1ns/1ps
module sxr_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Asynchronous in, synchronised out
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// Two flip-flops; pins idle high so reset to ones
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {WIDTH{1'b1}};
			sync_r <= {WIDTH{1'b1}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule

// ### core/sxr_slave.v
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "sxr_regs.vh"
module sxr_slave (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST_N,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [35:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Arbitration pins
	input wire EXT_REQUEST_N,
	output reg RELEASE_N,
	input wire INBOUND_VALID_N,
	output reg OUTBOUND_VALID_N,
	// Address/data bus and check bits
	input wire [31:0] ADDR_DATA_BUS_I,
	output reg [31:0] ADDR_DATA_BUS_O,
	output reg ADDR_DATA_BUS_OE,
	input wire [7:0] ADDR_DATA_CHECK_BUS_I,
	output reg [7:0] ADDR_DATA_CHECK_BUS_O,
	output reg ADDR_DATA_CHECK_BUS_OE,
	// Command bus and parity
	input wire [8:0] COMMAND_ID_BUS_I,
	output reg [8:0] COMMAND_ID_BUS_O,
	output reg COMMAND_ID_BUS_OE,
	input wire COMMAND_PARITY_I,
	output reg COMMAND_PARITY_O,
	output reg COMMAND_PARITY_OE,
	// Processor request port
	input wire CORE_REQ_VALID,
	output wire CORE_REQ_READY,
	input wire [8:0] CORE_REQ_CMD,
	input wire [31:0] CORE_REQ_ADDR,
	input wire [31:0] CORE_WR_DATA,
	output wire CORE_WR_NEXT,
	// Read response to processor
	output reg [31:0] RESP_DATA,
	output reg RESP_VALID,
	output reg RESP_LAST,
	output reg RESP_BUS_ERR,
	output reg RESP_EXCL_DIRTY,
	// External write to processor
	output reg EXT_WR_VALID,
	output reg [31:0] EXT_WR_ADDR,
	output reg [31:0] EXT_WR_DATA
);
	localparam [12:0] ST_MASTER = 13'h0001;
	localparam [12:0] ST_REL = 13'h0002;
	localparam [12:0] ST_SLAVE = 13'h0004;
	localparam [12:0] ST_EWDATA = 13'h0008;
	localparam [12:0] ST_ERD_FLT = 13'h0010;
	localparam [12:0] ST_ERD_RSP = 13'h0020;
	localparam [12:0] ST_GAP = 13'h0040;
	localparam [12:0] ST_PRD_ADR = 13'h0080;
	localparam [12:0] ST_PRD_REL = 13'h0100;
	localparam [12:0] ST_PRD_RSP = 13'h0200;
	localparam [12:0] ST_PWR_ADR = 13'h0400;
	localparam [12:0] ST_PWR_DAT = 13'h0800;
	localparam [12:0] ST_PWR_IDL = 13'h1000;

	reg [1:0] rst_ff_r;
	wire rst_n_s;
	wire [51:0] pins_s;
	wire ext_req_n_s;
	wire in_valid_n_s;
	wire [31:0] ad_in_s;
	wire [7:0] chk_in_s;
	wire [8:0] cmd_in_s;
	wire par_in_s;
	wire [7:0] chk_in_calc;
	wire [7:0] chk_nxt;
	reg [12:0] st_r, st_nxt;
	reg [1:0] gap_r, gap_nxt;
	reg [2:0] cnt_r, cnt_nxt;
	reg [8:0] pcmd_r, pcmd_nxt;
	reg err_r, err_nxt;
	reg rel_n_nxt, ov_n_nxt, oe_nxt;
	reg [31:0] ad_nxt;
	reg [8:0] cmd_nxt;
	reg send_word;
	reg resp_v_nxt, resp_last_nxt, resp_err_nxt, resp_xd_nxt;
	reg ewr_v_nxt;
	reg [31:0] ewr_addr_nxt;
	reg [2:0] cfg_r;
	reg perr_r;
	reg berr_r;
	wire in_cmd_cyc;
	wire in_dat_cyc;
	wire perr_set;
	wire apb_wr;
	wire hit_cfg;
	wire hit_stat;

	// Reset release through two flip-flops
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_ff_r <= 2'h0;
		end else begin
			rst_ff_r <= {rst_ff_r[0], 1'b1};
		end
	end
	assign rst_n_s = rst_ff_r[1];

	// All pin inputs pass two flip-flops
	sxr_sync #(.WIDTH(52)) u_pin_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n_s),
		.d({EXT_REQUEST_N, INBOUND_VALID_N, ADDR_DATA_BUS_I,
			ADDR_DATA_CHECK_BUS_I, COMMAND_ID_BUS_I, COMMAND_PARITY_I}),
		.q(pins_s)
	);
	assign ext_req_n_s = pins_s[51];
	assign in_valid_n_s = pins_s[50];
	assign ad_in_s = pins_s[49:18];
	assign chk_in_s = pins_s[17:10];
	assign cmd_in_s = pins_s[9:1];
	assign par_in_s = pins_s[0];

	// Inbound cycle classes by valid and bus MSB
	assign in_cmd_cyc = !in_valid_n_s && !cmd_in_s[`SXR_CMD_DATA_BIT]; // R24
	assign in_dat_cyc = !in_valid_n_s && cmd_in_s[`SXR_CMD_DATA_BIT]; // R21

	// Per-byte even check bits, outbound and inbound
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_chk
			assign chk_nxt[i] = ^ad_nxt[8*i+7:8*i];
			assign chk_in_calc[i] = ^ad_in_s[8*i+7:8*i];
		end
	endgenerate
	// Upper check bits have no byte lane on a 32-bit bus
	assign chk_nxt[7:4] = 4'h0;
	assign chk_in_calc[7:4] = 4'h0;
	assign perr_set = !in_valid_n_s && ((chk_in_calc != chk_in_s) ||
		((^cmd_in_s) != par_in_s));

	// Interface sequencer
	always @* begin
		st_nxt = st_r;
		gap_nxt = gap_r;
		cnt_nxt = cnt_r;
		pcmd_nxt = pcmd_r;
		err_nxt = err_r;
		rel_n_nxt = 1'b1;
		ov_n_nxt = 1'b1;
		oe_nxt = COMMAND_ID_BUS_OE;
		ad_nxt = ADDR_DATA_BUS_O;
		cmd_nxt = COMMAND_ID_BUS_O;
		send_word = 1'b0;
		resp_v_nxt = 1'b0;
		resp_last_nxt = 1'b0;
		resp_err_nxt = RESP_BUS_ERR;
		resp_xd_nxt = 1'b0;
		ewr_v_nxt = 1'b0;
		ewr_addr_nxt = EXT_WR_ADDR;
		case (st_r)
			ST_MASTER: begin
				oe_nxt = 1'b1;
				if (!ext_req_n_s) begin
					st_nxt = ST_REL;
					rel_n_nxt = 1'b0; // R1
					oe_nxt = 1'b0; // R2
				end else if (CORE_REQ_VALID) begin
					cmd_nxt = CORE_REQ_CMD;
					ad_nxt = CORE_REQ_ADDR;
					ov_n_nxt = 1'b0;
					pcmd_nxt = CORE_REQ_CMD;
					err_nxt = 1'b0;
					if (CORE_REQ_CMD[`SXR_CMD_PROP_HI:`SXR_CMD_PROP_LO] ==
						`SXR_PROP_BLOCK) begin
						cnt_nxt = `SXR_BLOCK_LAST;
					end else begin
						cnt_nxt = `SXR_SINGLE_LAST;
					end
					if (CORE_REQ_CMD[`SXR_CMD_TYPE_HI:`SXR_CMD_TYPE_LO] ==
						`SXR_TYPE_READ) begin
						st_nxt = ST_PRD_ADR;
					end else begin
						st_nxt = ST_PWR_ADR;
					end
				end
			end
			ST_REL: begin
				st_nxt = ST_SLAVE; // R9
			end
			ST_SLAVE: begin
				// Valid stays high during independent transfers
				if (in_cmd_cyc) begin // R23
					case (cmd_in_s[`SXR_CMD_TYPE_HI:`SXR_CMD_TYPE_LO]) // R25
						`SXR_TYPE_READ: begin
							st_nxt = ST_ERD_FLT; // R8
						end
						`SXR_TYPE_WRITE: begin
							ewr_addr_nxt = ad_in_s;
							st_nxt = ST_EWDATA;
						end
						`SXR_TYPE_NULL: begin
							gap_nxt = `SXR_HANDBACK_CYC; // R14
							st_nxt = ST_GAP;
						end
						default: begin
							st_nxt = ST_SLAVE;
						end
					endcase
				end
			end
			ST_EWDATA: begin
				if (in_dat_cyc) begin // R21
					ewr_v_nxt = 1'b1;
					gap_nxt = `SXR_HANDBACK_CYC;
					st_nxt = ST_GAP;
				end
			end
			ST_ERD_FLT: begin
				oe_nxt = 1'b1;
				cmd_nxt = `SXR_DID_RESP_ERR; // R11
				ad_nxt = 32'h0;
				ov_n_nxt = 1'b0;
				st_nxt = ST_ERD_RSP;
			end
			ST_ERD_RSP: begin
				st_nxt = ST_MASTER; // R12
			end
			ST_GAP: begin
				if (gap_r == 2'h0) begin
					oe_nxt = 1'b1;
					st_nxt = ST_MASTER; // R6
				end else begin
					gap_nxt = gap_r - 2'h1;
				end
			end
			ST_PRD_ADR: begin
				rel_n_nxt = 1'b0;
				oe_nxt = 1'b0;
				st_nxt = ST_PRD_REL;
			end
			ST_PRD_REL: begin
				st_nxt = ST_PRD_RSP;
			end
			ST_PRD_RSP: begin
				if (in_dat_cyc) begin // R21
					resp_v_nxt = 1'b1;
					err_nxt = err_r | cmd_in_s[`SXR_DID_ERR_BIT];
					if (cmd_in_s[`SXR_DID_LAST_BIT]) begin
						resp_last_nxt = 1'b1;
						resp_err_nxt = err_nxt; // R19
						resp_xd_nxt =
							pcmd_r[`SXR_CMD_PROP_HI:`SXR_CMD_PROP_LO] ==
							`SXR_PROP_BLOCK; // R18
						gap_nxt = `SXR_HANDBACK_CYC;
						st_nxt = ST_GAP;
					end
				end
			end
			ST_PWR_ADR: begin
				send_word = 1'b1;
			end
			ST_PWR_DAT: begin
				if (cnt_r == 3'h0) begin
					if (pcmd_r[`SXR_CMD_PROP_HI:`SXR_CMD_PROP_LO] !=
						`SXR_PROP_BLOCK &&
						cfg_r[`SXR_CFG_SWM_HI:`SXR_CFG_SWM_LO] ==
						`SXR_SWM_COMPAT) begin
						gap_nxt = `SXR_COMPAT_DUMMY;
						st_nxt = ST_GAP;
					end else begin
						st_nxt = ST_MASTER;
					end
				end else begin
					cnt_nxt = cnt_r - 3'h1;
					if (cfg_r[`SXR_CFG_PAT_BIT]) begin // R22
						send_word = 1'b1;
					end else begin
						gap_nxt = `SXR_WXX_IDLE; // R22
						st_nxt = ST_PWR_IDL;
					end
				end
			end
			ST_PWR_IDL: begin
				if (gap_r == 2'h0) begin
					send_word = 1'b1;
				end else begin
					gap_nxt = gap_r - 2'h1;
				end
			end
			default: begin
				st_nxt = ST_MASTER;
			end
		endcase
		// One outbound data word of a processor write
		if (send_word) begin
			ad_nxt = CORE_WR_DATA;
			ov_n_nxt = 1'b0;
			st_nxt = ST_PWR_DAT;
			if (cnt_nxt == 3'h0) begin
				cmd_nxt = `SXR_DID_WR_LAST;
			end else begin
				cmd_nxt = `SXR_DID_WR_MORE;
			end
		end
	end

	// Core may issue only in master with no request pending
	assign CORE_REQ_READY = (st_r == ST_MASTER) && ext_req_n_s; // R6
	assign CORE_WR_NEXT = send_word;

	// Sequencer and pin output registers
	always @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_r <= ST_MASTER;
			gap_r <= 2'h0;
			cnt_r <= 3'h0;
			pcmd_r <= 9'h0;
			err_r <= 1'b0;
			RELEASE_N <= 1'b1;
			OUTBOUND_VALID_N <= 1'b1;
			ADDR_DATA_BUS_O <= 32'h0;
			ADDR_DATA_CHECK_BUS_O <= 8'h0;
			COMMAND_ID_BUS_O <= 9'h0;
			COMMAND_PARITY_O <= 1'b0;
			ADDR_DATA_BUS_OE <= 1'b1;
			ADDR_DATA_CHECK_BUS_OE <= 1'b1;
			COMMAND_ID_BUS_OE <= 1'b1;
			COMMAND_PARITY_OE <= 1'b1;
		end else begin
			st_r <= st_nxt;
			gap_r <= gap_nxt;
			cnt_r <= cnt_nxt;
			pcmd_r <= pcmd_nxt;
			err_r <= err_nxt;
			RELEASE_N <= rel_n_nxt;
			OUTBOUND_VALID_N <= ov_n_nxt;
			ADDR_DATA_BUS_O <= ad_nxt;
			ADDR_DATA_CHECK_BUS_O <= chk_nxt; // R7
			COMMAND_ID_BUS_O <= cmd_nxt;
			COMMAND_PARITY_O <= ^cmd_nxt; // R7
			ADDR_DATA_BUS_OE <= oe_nxt;
			ADDR_DATA_CHECK_BUS_OE <= oe_nxt; // R7
			COMMAND_ID_BUS_OE <= oe_nxt;
			COMMAND_PARITY_OE <= oe_nxt; // R7
		end
	end

	// Processor-side result registers
	always @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			RESP_DATA <= 32'h0;
			RESP_VALID <= 1'b0;
			RESP_LAST <= 1'b0;
			RESP_BUS_ERR <= 1'b0;
			RESP_EXCL_DIRTY <= 1'b0;
			EXT_WR_VALID <= 1'b0;
			EXT_WR_ADDR <= 32'h0;
			EXT_WR_DATA <= 32'h0;
		end else begin
			if (resp_v_nxt) begin
				RESP_DATA <= ad_in_s;
			end
			RESP_VALID <= resp_v_nxt;
			RESP_LAST <= resp_last_nxt;
			RESP_BUS_ERR <= resp_err_nxt;
			RESP_EXCL_DIRTY <= resp_xd_nxt;
			EXT_WR_VALID <= ewr_v_nxt;
			EXT_WR_ADDR <= ewr_addr_nxt;
			if (ewr_v_nxt) begin
				EXT_WR_DATA <= ad_in_s;
			end
		end
	end

	// APB decode
	assign hit_cfg = (PADDR == `SXR_CFG_ADDR);
	assign hit_stat = (PADDR == `SXR_STAT_ADDR);
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit_cfg && !hit_stat;

	// Config, sticky parity error (set wins over clear), read data
	always @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			cfg_r <= `SXR_CFG_RST; // R22
			perr_r <= 1'b0;
			berr_r <= 1'b0;
			PRDATA <= 32'h0;
		end else begin
			if (apb_wr && hit_cfg) begin
				cfg_r <= PWDATA[2:0];
			end
			if (perr_set) begin
				perr_r <= 1'b1;
			end else if (apb_wr && hit_stat && PWDATA[`SXR_ST_PERR_BIT]) begin
				perr_r <= 1'b0;
			end
			if (resp_last_nxt) begin
				berr_r <= resp_err_nxt;
			end
			if (PSEL && !PENABLE && !PWRITE) begin
				if (hit_cfg) begin
					PRDATA <= {29'h0, cfg_r};
				end else if (hit_stat) begin
					PRDATA <= {29'h0, berr_r, perr_r, st_r == ST_MASTER};
				end else begin
					PRDATA <= 32'h0;
				end
			end
		end
	end
endmodule

// ### tb/sxr_checker.sv
`timescale 1ns/1ps
module sxr_checker (
	// Clock and reset
	input logic CLK_SYS,
	input logic RST_N,
	// Device side of the pins
	input logic RELEASE_N,
	input logic OUTBOUND_VALID_N,
	input logic ADDR_DATA_BUS_OE,
	input logic ADDR_DATA_CHECK_BUS_OE,
	input logic [8:0] COMMAND_ID_BUS_O,
	input logic COMMAND_ID_BUS_OE,
	input logic COMMAND_PARITY_O,
	input logic COMMAND_PARITY_OE,
	input logic CORE_REQ_READY
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// Steps of a grant and of a read answer
	sequence s_grant;
		$fell(RELEASE_N);
	endsequence
	sequence s_float;
		!ADDR_DATA_BUS_OE && !COMMAND_ID_BUS_OE;
	endsequence
	sequence s_answer;
		!OUTBOUND_VALID_N && COMMAND_ID_BUS_O[8] && COMMAND_ID_BUS_O[6];
	endsequence
	release_pulse_a: assert property (s_grant |=> RELEASE_N)
		else $error("release longer than one cycle");
	grant_float_a: assert property (!RELEASE_N |-> s_float)
		else $error("bus driven during grant");
	float_hold_a: assert property (s_grant |=> s_float[*2])
		else $error("bus driven too soon after grant");
	oe_follow_a: assert property (
		ADDR_DATA_CHECK_BUS_OE == ADDR_DATA_BUS_OE &&
		COMMAND_PARITY_OE == COMMAND_ID_BUS_OE)
		else $error("companion enable differs");
	parity_a: assert property (
		COMMAND_PARITY_OE |-> COMMAND_PARITY_O == ^COMMAND_ID_BUS_O)
		else $error("command parity wrong");
	answer_bits_a: assert property (
		s_answer |-> COMMAND_ID_BUS_O[7] && COMMAND_ID_BUS_O[5])
		else $error("read answer not final with error");
	master_keep_a: assert property (
		s_answer |=> ADDR_DATA_BUS_OE && COMMAND_ID_BUS_OE)
		else $error("bus dropped after read answer");
	oe_drop_a: assert property (
		$fell(ADDR_DATA_BUS_OE) |-> !RELEASE_N)
		else $error("bus floated without a grant");
	no_core_slave_a: assert property (
		!COMMAND_ID_BUS_OE |-> !CORE_REQ_READY)
		else $error("core request while bus released");
	cmd_type_a: assert property (
		!OUTBOUND_VALID_N && !COMMAND_ID_BUS_O[8] |->
		COMMAND_ID_BUS_O[7:5] inside {3'h0, 3'h2})
		else $error("bad command type");
endmodule

bind sxr_slave sxr_checker chk (
	.CLK_SYS, .RST_N, .RELEASE_N, .OUTBOUND_VALID_N, .ADDR_DATA_BUS_OE,
	.ADDR_DATA_CHECK_BUS_OE, .COMMAND_ID_BUS_O, .COMMAND_ID_BUS_OE,
	.COMMAND_PARITY_O, .COMMAND_PARITY_OE, .CORE_REQ_READY
);

// ### tb/sxr_agent.sv
`timescale 1ns/1ps
module sxr_agent (
	// Clock and grant
	input logic clk,
	input logic release_n,
	// Request and valid
	output logic ext_request_n,
	output logic inbound_valid_n,
	// Bus drive
	output logic oe,
	output logic [31:0] ad,
	output logic [8:0] cmd,
	output logic [7:0] ck,
	output logic par
);
	// Companions track the primary buses
	assign ck = {4'h0, ^ad[31:24], ^ad[23:16], ^ad[15:8], ^ad[7:0]};
	assign par = ^cmd;
	// Idle with buses released
	initial begin
		ext_request_n = 1;
		inbound_valid_n = 1;
		oe = 0;
		ad = 0;
		cmd = 0;
	end
	// Wait for the grant, then two edges before driving
	task wrel();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (release_n !== 0 && n < 200);
		repeat (2) @(posedge clk);
	endtask
	// Ask for the bus, drop the ask once driving
	task grab();
		ext_request_n <= 0;
		wrel();
		ext_request_n <= 1;
	endtask
	// One bus cycle
	task send(input logic [8:0] c, input logic [31:0] d, input logic v);
		oe <= 1;
		cmd <= c;
		ad <= d;
		inbound_valid_n <= !v;
		@(posedge clk);
	endtask
	// Hand the buses back
	task flt();
		oe <= 0;
		inbound_valid_n <= 1;
	endtask
	// Answer a pending read, word e flagged bad
	task rsp(input int k, input int e);
		wrel();
		for (int i = 0; i < k; i++)
			send({1'b1, i == k - 1, 1'b1, i == e, 5'h1f}, 32'h500 + i, 1);
		flt();
	endtask
endmodule

// ### tb/tb_sysbus_external_request_slave.sv
`timescale 1ns/1ps
`include "sxr_regs.vh"
module tb_sysbus_external_request_slave;
	logic CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, CORE_REQ_VALID, erv;
	logic [35:0] PADDR;
	logic [31:0] PWDATA, CORE_REQ_ADDR, CORE_WR_DATA, rdv, w0, ad_l, wv;
	logic [8:0] CORE_REQ_CMD, cmd_l;
	logic [7:0] ck_l, cv;
	logic par_l;
	int fail_count, n_compared, cyc, t0;
	wire PREADY, PSLVERR, RELEASE_N, OUTBOUND_VALID_N, EXT_REQUEST_N;
	wire INBOUND_VALID_N, ADDR_DATA_BUS_OE, ADDR_DATA_CHECK_BUS_OE, ag_oe;
	wire COMMAND_ID_BUS_OE, COMMAND_PARITY_O, COMMAND_PARITY_OE, ag_p;
	wire CORE_REQ_READY, CORE_WR_NEXT, RESP_VALID, RESP_LAST;
	wire RESP_BUS_ERR, RESP_EXCL_DIRTY, EXT_WR_VALID, COMMAND_PARITY_I;
	wire [31:0] PRDATA, ADDR_DATA_BUS_O, RESP_DATA, EXT_WR_ADDR, ag_ad;
	wire [31:0] EXT_WR_DATA, ADDR_DATA_BUS_I;
	wire [7:0] ADDR_DATA_CHECK_BUS_O, ADDR_DATA_CHECK_BUS_I, ag_ck;
	wire [8:0] COMMAND_ID_BUS_O, COMMAND_ID_BUS_I, ag_cmd;
	wire [3:0] ev;
	// Pin levels; a floating bus shows the inverse of its last value
	assign ADDR_DATA_BUS_I = ADDR_DATA_BUS_OE ? ADDR_DATA_BUS_O :
		ag_oe ? ag_ad : ~ad_l;
	assign ADDR_DATA_CHECK_BUS_I = ADDR_DATA_CHECK_BUS_OE ?
		ADDR_DATA_CHECK_BUS_O : ag_oe ? ag_ck : ~ck_l;
	assign COMMAND_ID_BUS_I = COMMAND_ID_BUS_OE ? COMMAND_ID_BUS_O :
		ag_oe ? ag_cmd : ~cmd_l;
	assign COMMAND_PARITY_I = COMMAND_PARITY_OE ? COMMAND_PARITY_O :
		ag_oe ? ag_p : ~par_l;
	assign ev = {RESP_VALID, EXT_WR_VALID, ~OUTBOUND_VALID_N,
		ADDR_DATA_BUS_OE};
	// Last levels, cycle count and the core write data source
	always @(posedge CLK_SYS) begin
		ad_l <= ADDR_DATA_BUS_I;
		ck_l <= ADDR_DATA_CHECK_BUS_I;
		cmd_l <= COMMAND_ID_BUS_I;
		par_l <= COMMAND_PARITY_I;
		cyc <= cyc + 1;
		if (CORE_WR_NEXT)
			CORE_WR_DATA <= CORE_WR_DATA + 1;
	end
	sxr_slave dut (
		.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .EXT_REQUEST_N, .RELEASE_N,
		.INBOUND_VALID_N, .OUTBOUND_VALID_N, .ADDR_DATA_BUS_I,
		.ADDR_DATA_BUS_O, .ADDR_DATA_BUS_OE, .ADDR_DATA_CHECK_BUS_I,
		.ADDR_DATA_CHECK_BUS_O, .ADDR_DATA_CHECK_BUS_OE, .COMMAND_ID_BUS_I,
		.COMMAND_ID_BUS_O, .COMMAND_ID_BUS_OE, .COMMAND_PARITY_I,
		.COMMAND_PARITY_O, .COMMAND_PARITY_OE, .CORE_REQ_VALID,
		.CORE_REQ_READY, .CORE_REQ_CMD, .CORE_REQ_ADDR, .CORE_WR_DATA,
		.CORE_WR_NEXT, .RESP_DATA, .RESP_VALID, .RESP_LAST, .RESP_BUS_ERR,
		.RESP_EXCL_DIRTY, .EXT_WR_VALID, .EXT_WR_ADDR, .EXT_WR_DATA
	);
	sxr_agent ag (
		.clk(CLK_SYS), .release_n(RELEASE_N), .ext_request_n(EXT_REQUEST_N),
		.inbound_valid_n(INBOUND_VALID_N), .oe(ag_oe), .ad(ag_ad),
		.cmd(ag_cmd), .ck(ag_ck), .par(ag_p)
	);
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task tally_and_finish();
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task lim(input int n);
		if (n == 200) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	// Wait for event k seen settled after an edge
	task wt(input int k);
		int n;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end while (ev[k] !== 1 && n < 200);
		lim(n);
	endtask
	task apb(input logic w, input logic [35:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (PREADY !== 1 && n < 200);
		lim(n);
		rdv = PRDATA;
		erv = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task core(input logic [8:0] c);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		CORE_REQ_CMD <= c;
		CORE_REQ_VALID <= 1;
		#1;
		while (CORE_REQ_READY !== 1 && n < 200) begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end
		lim(n);
		@(posedge CLK_SYS);
		CORE_REQ_VALID <= 0;
	endtask
	// Processor read answered by the agent
	task rd(input logic [8:0] c, input int k, input int e);
		fork
			core(c);
			ag.rsp(k, e);
			for (int i = 0; i < k; i++) begin
				wt(3);
				chk(RESP_DATA, 32'h500 + i);
				chk(RESP_LAST, i == k - 1);
			end
		join
		chk(RESP_EXCL_DIRTY, k == 8);
		@(posedge CLK_SYS);
		#1;
		chk(RESP_BUS_ERR, e < k);
	endtask
	// Block write spacing under each pattern
	task bw(input logic p);
		apb(1, `SXR_CFG_ADDR, {31'h0, p});
		apb(0, `SXR_CFG_ADDR, 0);
		chk(rdv, p);
		w0 = CORE_WR_DATA;
		fork
			core(9'h051);
			for (int k = 0; k < 9; k++) begin
				wt(1);
				if (k == 0) begin
					chk(ADDR_DATA_BUS_O, 32'h200);
					chk(COMMAND_ID_BUS_O, 9'h051);
				end
				if (k == 1)
					t0 = cyc;
				if (k > 0) begin
					wv = w0 + k - 1;
					cv = {4'h0, ^wv[31:24], ^wv[23:16], ^wv[15:8], ^wv[7:0]};
					chk(ADDR_DATA_BUS_O, wv);
					chk(ADDR_DATA_CHECK_BUS_O, cv);
				end
			end
		join
		chk(cyc - t0, p ? 7 : 21);
	endtask
	initial begin
		CLK_SYS = 0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	// Main sequence
	initial begin
		RST_N = 0;
		PSEL = 0;
		PENABLE = 0;
		PWRITE = 0;
		PADDR = 0;
		PWDATA = 0;
		CORE_REQ_VALID = 0;
		CORE_REQ_CMD = 0;
		CORE_REQ_ADDR = 32'h200;
		CORE_WR_DATA = 32'h100;
		repeat (10) @(posedge CLK_SYS);
		RST_N <= 1;
		repeat (3) @(posedge CLK_SYS);
		apb(0, `SXR_CFG_ADDR, 0);
		chk(rdv, 0);
		apb(0, 36'hfff100010, 0);
		chk(erv, 1);
		ag.grab();
		ag.send(9'h05b, 32'h40, 1);
		ag.send(9'h19f, 32'h77, 1);
		ag.flt();
		wt(2);
		chk(EXT_WR_ADDR, 32'h40);
		chk(EXT_WR_DATA, 32'h77);
		wt(0);
		ag.grab();
		ag.send(9'h1ff, 32'h9, 0);
		ag.send(9'h067, 32'h0, 1);
		ag.flt();
		wt(0);
		apb(0, `SXR_STAT_ADDR, 0);
		chk(rdv[2:0], 3'h1);
		chk(EXT_WR_DATA, 32'h77);
		ag.grab();
		ag.send(9'h01b, 32'h80, 1);
		ag.flt();
		wt(1);
		chk(COMMAND_ID_BUS_O, 9'h1ff);
		@(posedge CLK_SYS);
		#1;
		chk(ADDR_DATA_BUS_OE, 1);
		rd(9'h01b, 1, 0);
		rd(9'h011, 8, 3);
		rd(9'h01b, 1, 1);
		bw(0);
		bw(1);
		// Single write in compatible mode: two dummy cycles after data
		fork
			core(9'h05b);
			begin
				wt(1);
				chk(COMMAND_ID_BUS_O, 9'h05b);
				wt(1);
				chk(COMMAND_ID_BUS_O, 9'h19f);
			end
		join
		repeat (2) begin
			@(posedge CLK_SYS);
			#1;
			chk(CORE_REQ_READY, 0);
		end
		@(posedge CLK_SYS);
		#1;
		chk(CORE_REQ_READY, 1);
		// Reset in mid-run returns the config to its default
		@(posedge CLK_SYS);
		RST_N <= 0;
		repeat (2) @(posedge CLK_SYS);
		RST_N <= 1;
		repeat (3) @(posedge CLK_SYS);
		apb(0, `SXR_CFG_ADDR, 0);
		chk(rdv, 0);
		tally_and_finish();
	end
endmodule
